// ==== rtl/periph_dma_defines.svh ====
// timing, selection and reset constants of the peripheral dma and suspend logic
`ifndef PERIPH_DMA_DEFINES_SVH
`define PERIPH_DMA_DEFINES_SVH
`define PD_CLK_KHZ 20000
`define PD_IDLE_US 3000
`define PD_CLKOFF_US 2000
`define PD_MINSUSP_US 5000
`define PD_KDRIVE_US 10000
`define PD_US_TO_CYC(us) (((us) * `PD_CLK_KHZ + 999) / 1000)
`define PD_WORD_BYTES 16'h0002
`define PD_EPSEL_FIRST 4'h2
`define PD_CNT_RST 16'h0000
`endif

// ==== rtl/periph_dma_pkg.sv ====
// state types of the peripheral dma and suspend logic
package periph_dma_pkg;
  typedef enum logic [1:0] {XS_IDLE, XS_RUN, XS_DONE} xfer_state_e;
  typedef enum logic [2:0] {SS_ACTIVE, SS_ARMED, SS_ENTER, SS_SUSP, SS_KDRIVE} susp_state_e;
endpackage

// ==== rtl/word_stream_if.sv ====
// valid/ready word stream between the controller and its buffer
`timescale 1ns/10ps
interface word_stream_if #(parameter int W = 17);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/word_buffer.sv ====
// small first-in first-out word buffer with valid/ready on both sides
`timescale 1ns/10ps
module word_buffer #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  input  wire logic  core_clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  clk_en_in,
  input  wire logic  flush_in,
  word_stream_if.snk fill,
  word_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("word_buffer depth must be a power of two of at least two");
  end
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;
  assign fill.ready  = (cnt_r != (AW + 1)'(DEPTH));
  assign drain.valid = (cnt_r != '0);
  assign drain.data  = mem_r[rd_r];
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge core_clk_in)
      if (clk_en_in && push && wr_r == AW'(i))
        mem_r[i] <= fill.data;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else if (clk_en_in)
    begin
      if (flush_in)
      begin
        wr_r  <= '0;
        rd_r  <= '0;
        cnt_r <= '0;
      end
      else
      begin
        wr_r  <= wr_r + AW'(push);
        rd_r  <= rd_r + AW'(pop);
        cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
    end
endmodule

// ==== rtl/down_timer.sv ====
// loadable down counter that flags when it has run out
`timescale 1ns/10ps
module down_timer #(
  parameter int unsigned MAXC = 200000
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      clk_en_in,
  input  wire logic                      load_in,
  input  wire logic [$clog2(MAXC+1)-1:0] value_in,
  output logic                           done_out
);
  localparam int CW = $clog2(MAXC + 1);
  logic [CW-1:0] cnt_r;
  if (MAXC < 1)
  begin : g_bad_max
    $error("down_timer needs a count of at least one");
  end
  assign done_out = (cnt_r == '0);
  // reset to the full count so nothing reads as expired straight after reset
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt_r <= CW'(MAXC);
    else if (clk_en_in)
    begin
      if (load_in)
        cnt_r <= value_in;
      else if (!done_out)
        cnt_r <= cnt_r - CW'(1);
    end
endmodule

// ==== rtl/periph_dma_eot_suspend_ctrl.sv ====
// fly-by dma slave with end-of-transfer detection and usb suspend/wake control
// Operation
// - request dma while the selected endpoint has a ready packet or room
// - with acknowledge and read strobe active, drive the word onto the data bus
// - drop request after each word in single mode, after last word in burst
// - stop driving the data bus once acknowledge is removed
// - load byte counter on enable; with count termination, end at zero
// - short packet on bulk out ends dma after its last word moved
// - bulk in with short termination ends when counter hits zero mid-buffer
// - clearing the enable halts dma at once without an event
// - isochronous ends on count, end of packet or enable cleared
// - suspend is seen after 3 ms idle bus or loss of bus power
// - set suspend flag after 3 ms without frames; interrupt only if enabled
// - with clock run cleared, internal clocks stop while suspended
// - go-suspend set then cleared enters suspend, pin high, clocks off 2 ms later
// - remain suspended at least 5 ms before honouring wake events
// - wake on host k-state, low wake pin pulse, or enabled chip select
// - remote wake drives a k-state on the bus for 10 ms
// - endpoint codes 2 to 15 select endpoints 1 to 14; direction bit sets way
// - use the request/acknowledge handshake while ack-only mode is cleared
// - on wake drive pin low, set resume flag, interrupt only if enabled
// - after wake, register access is refused until the unlock command
`timescale 1ns/10ps
`include "periph_dma_defines.svh"
module periph_dma_eot_suspend_ctrl #(
  parameter int unsigned IDLE_CYC    = `PD_US_TO_CYC(`PD_IDLE_US),
  parameter int unsigned CLKOFF_CYC  = `PD_US_TO_CYC(`PD_CLKOFF_US),
  parameter int unsigned MINSUSP_CYC = `PD_US_TO_CYC(`PD_MINSUSP_US),
  parameter int unsigned KDRIVE_CYC  = `PD_US_TO_CYC(`PD_KDRIVE_US),
  parameter int          BURST_W     = 3,
  parameter int          BUF_DEPTH   = 2
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               clk_en_in,
  input  wire logic               dma_enable_bit_in,
  input  wire logic               count_termination_enable_in,
  input  wire logic               short_packet_termination_enable_in,
  input  wire logic [3:0]         dma_endpoint_select_in,
  input  wire logic               endpoint_direction_bit_in,
  input  wire logic               iso_endpoint_in,
  input  wire logic               ack_only_mode_bit_in,
  input  wire logic               burst_mode_in,
  input  wire logic [BURST_W-1:0] burst_len_in,
  input  wire logic [15:0]        dma_byte_count_reg_in,
  input  wire logic               dma_acknowledge_in,
  input  wire logic               dma_read_strobe_in,
  input  wire logic               dma_write_strobe_in,
  input  wire logic               transfer_termination_in,
  input  wire logic [15:0]        data_in,
  output logic [15:0]             data_out,
  output logic                    data_oe_out,
  output logic                    dma_request_out,
  output logic                    eot_event_out,
  output logic [3:0]              dma_endpoint_out,
  output logic [15:0]             dma_count_left_out,
  input  wire logic               ep_packet_ready_in,
  input  wire logic               ep_rd_valid_in,
  input  wire logic [15:0]        ep_rd_data_in,
  input  wire logic               ep_rd_short_last_in,
  output logic                    ep_rd_ready_out,
  output logic                    ep_wr_valid_out,
  output logic [15:0]             ep_wr_data_out,
  input  wire logic               ep_wr_ready_in,
  input  wire logic               ep_in_partial_in,
  input  wire logic               ep_eop_in,
  input  wire logic               bus_idle_in,
  input  wire logic               sof_in,
  input  wire logic               vbus_present_in,
  input  wire logic               bus_k_state_in,
  input  wire logic               go_suspend_bit_in,
  input  wire logic               clock_run_bit_in,
  input  wire logic               chip_select_wake_enable_in,
  input  wire logic               chip_select_n_in,
  input  wire logic               suspend_wake_pin_in,
  output logic                    suspend_wake_pin_out,
  output logic                    suspend_wake_pin_oe_out,
  input  wire logic               suspend_irq_enable_in,
  input  wire logic               resume_irq_enable_in,
  input  wire logic [1:0]         irq_flag_clear_in,
  input  wire logic               unlock_device_in,
  output logic                    suspend_flag_out,
  output logic                    resume_flag_out,
  output logic                    irq_out,
  output logic                    bus_state_bit_out,
  output logic                    internal_clk_run_out,
  output logic                    drive_k_state_out,
  output logic                    register_lock_out
);
  localparam int unsigned TMAX = (KDRIVE_CYC > MINSUSP_CYC) ?
    ((KDRIVE_CYC > CLKOFF_CYC) ? KDRIVE_CYC : CLKOFF_CYC) :
    ((MINSUSP_CYC > CLKOFF_CYC) ? MINSUSP_CYC : CLKOFF_CYC);
  localparam int TW = $clog2(TMAX + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);
  if (IDLE_CYC < 2 || CLKOFF_CYC < 2 || MINSUSP_CYC < 2 || KDRIVE_CYC < 2 ||
      BURST_W < 1 || BURST_W > 4)
  begin : g_bad_cfg
    $error("suspend counts must be at least two and burst width 1 to 4");
  end

  word_stream_if #(.W(17)) buf_fill ();
  word_stream_if #(.W(17)) buf_drain ();

  periph_dma_pkg::xfer_state_e xs_r;
  periph_dma_pkg::susp_state_e ss_r;
  periph_dma_pkg::susp_state_e ss_nxt;
  logic [15:0]        cnt_r;
  logic [15:0]        wr_data_r;
  logic [BURST_W-1:0] burst_r;
  logic [TW-1:0]      st_value;
  logic en_q_r, rd_q_r, wr_q_r, hold_r, susp_cond_q_r;
  logic dir_in, sel_ok, fly_by, rd_done, wr_done, word_done, cnt_hit, avail;
  logic eot_cond, idle_done, susp_cond, st_done, wake_remote, wake_any;

  assign dir_in  = endpoint_direction_bit_in;
  assign sel_ok  = (dma_endpoint_select_in >= `PD_EPSEL_FIRST);
  assign fly_by  = !ack_only_mode_bit_in;
  assign dma_endpoint_out   = sel_ok ? dma_endpoint_select_in - 4'h1 : 4'h0;
  assign dma_count_left_out = cnt_r;
  // a word is complete when its strobe falls after being seen with acknowledge
  assign rd_done   = rd_q_r && !dma_read_strobe_in;
  assign wr_done   = wr_q_r && !dma_write_strobe_in;
  assign word_done = rd_done || wr_done;
  assign cnt_hit   = word_done && (cnt_r <= `PD_WORD_BYTES);

  // one buffer serves both directions; its far side follows the endpoint direction
  assign buf_fill.valid  = dir_in ? wr_done : ep_rd_valid_in && xs_r == periph_dma_pkg::XS_RUN;
  assign buf_fill.data   = dir_in ? {1'h0, wr_data_r} : {ep_rd_short_last_in, ep_rd_data_in};
  assign ep_rd_ready_out = !dir_in && buf_fill.ready && xs_r == periph_dma_pkg::XS_RUN;
  assign buf_drain.ready = dir_in ? ep_wr_ready_in : rd_done;
  assign ep_wr_valid_out = dir_in && buf_drain.valid;
  assign ep_wr_data_out  = buf_drain.data[15:0];
  assign data_out        = buf_drain.data[15:0];
  assign data_oe_out     = fly_by && dma_acknowledge_in && dma_read_strobe_in && !dir_in;

  word_buffer #(.W(17), .DEPTH(BUF_DEPTH)) u_buf (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .flush_in    (xs_r == periph_dma_pkg::XS_IDLE),
    .fill        (buf_fill),
    .drain       (buf_drain)
  );

  // writes only ask while a slot is free, so a stalled endpoint stops the dma side
  assign avail = dir_in ? buf_fill.ready && ep_packet_ready_in : buf_drain.valid;
  assign dma_request_out = fly_by && dma_enable_bit_in && sel_ok && avail && !hold_r &&
                           xs_r == periph_dma_pkg::XS_RUN;

  always_comb
  begin
    eot_cond = 1'h0;
    if (xs_r == periph_dma_pkg::XS_RUN && dma_enable_bit_in)
      eot_cond = (count_termination_enable_in && cnt_hit) ||
                 (short_packet_termination_enable_in && !iso_endpoint_in && !dir_in &&
                  rd_done && buf_drain.data[16]) ||
                 (short_packet_termination_enable_in && !iso_endpoint_in && dir_in &&
                  cnt_hit && ep_in_partial_in) ||
                 (iso_endpoint_in && ep_eop_in) ||
                 (transfer_termination_in && dma_acknowledge_in);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      xs_r          <= periph_dma_pkg::XS_IDLE;
      en_q_r        <= 1'h0;
      eot_event_out <= 1'h0;
    end
    else if (clk_en_in)
    begin
      en_q_r        <= dma_enable_bit_in;
      eot_event_out <= eot_cond;
      case (xs_r)
        periph_dma_pkg::XS_IDLE:
          if (dma_enable_bit_in && !en_q_r)
            xs_r <= periph_dma_pkg::XS_RUN;
        periph_dma_pkg::XS_RUN:
          if (!dma_enable_bit_in)
            xs_r <= periph_dma_pkg::XS_IDLE;
          else if (eot_cond)
            xs_r <= periph_dma_pkg::XS_DONE;
        periph_dma_pkg::XS_DONE:
          if (!dma_enable_bit_in)
            xs_r <= periph_dma_pkg::XS_IDLE;
        default:
          xs_r <= periph_dma_pkg::XS_IDLE;
      endcase
    end

  // byte counter: loaded on the enable edge, two bytes per word, stops at zero
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt_r <= `PD_CNT_RST;
    else if (clk_en_in)
    begin
      if (dma_enable_bit_in && !en_q_r)
        cnt_r <= dma_byte_count_reg_in;
      else if (cnt_hit)
        cnt_r <= `PD_CNT_RST;
      else if (word_done)
        cnt_r <= cnt_r - `PD_WORD_BYTES;
    end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rd_q_r    <= 1'h0;
      wr_q_r    <= 1'h0;
      wr_data_r <= 16'h0000;
    end
    else if (clk_en_in)
    begin
      rd_q_r <= fly_by && dma_acknowledge_in && dma_read_strobe_in && !dir_in &&
                buf_drain.valid;
      wr_q_r <= fly_by && dma_acknowledge_in && dma_write_strobe_in && dir_in &&
                buf_fill.ready;
      if (dma_acknowledge_in && dma_write_strobe_in)
        wr_data_r <= data_in;
    end

  // hold keeps the request low until acknowledge goes away
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      hold_r  <= 1'h0;
      burst_r <= '0;
    end
    else if (clk_en_in)
    begin
      if (word_done && (!burst_mode_in || burst_r == burst_len_in || eot_cond))
        hold_r <= 1'h1;
      else if (!dma_acknowledge_in)
        hold_r <= 1'h0;
      if (!dma_acknowledge_in)
        burst_r <= '0;
      else if (word_done)
        burst_r <= burst_r + BURST_W'(1);
    end

  // suspend detection: idle bus with no frames for the full idle time, or power loss
  down_timer #(.MAXC(IDLE_CYC)) u_idle (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .load_in     (!bus_idle_in || sof_in),
    .value_in    (IW'(IDLE_CYC - 1)),
    .done_out    (idle_done)
  );
  assign susp_cond         = idle_done || !vbus_present_in;
  assign bus_state_bit_out = susp_cond;
  assign wake_remote = !suspend_wake_pin_in ||
                       (chip_select_wake_enable_in && !chip_select_n_in);
  assign wake_any    = wake_remote || bus_k_state_in;

  always_comb
  begin
    ss_nxt   = ss_r;
    st_value = TW'(CLKOFF_CYC - 1);
    case (ss_r)
      periph_dma_pkg::SS_ACTIVE:
        if (go_suspend_bit_in && !register_lock_out)
          ss_nxt = periph_dma_pkg::SS_ARMED;
      periph_dma_pkg::SS_ARMED:
        if (!go_suspend_bit_in)
          ss_nxt = periph_dma_pkg::SS_ENTER;
      periph_dma_pkg::SS_ENTER:
      begin
        st_value = TW'(MINSUSP_CYC - 1);
        if (st_done)
          ss_nxt = periph_dma_pkg::SS_SUSP;
      end
      periph_dma_pkg::SS_SUSP:
      begin
        st_value = TW'(KDRIVE_CYC - 1);
        if (st_done && wake_remote)
          ss_nxt = periph_dma_pkg::SS_KDRIVE;
        else if (st_done && bus_k_state_in)
          ss_nxt = periph_dma_pkg::SS_ACTIVE;
      end
      periph_dma_pkg::SS_KDRIVE:
        if (st_done)
          ss_nxt = periph_dma_pkg::SS_ACTIVE;
      default:
        ss_nxt = periph_dma_pkg::SS_ACTIVE;
    endcase
  end

  down_timer #(.MAXC(TMAX)) u_state_tmr (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .load_in     (ss_nxt != ss_r),
    .value_in    (st_value),
    .done_out    (st_done)
  );

  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      ss_r <= periph_dma_pkg::SS_ACTIVE;
    else if (clk_en_in)
      ss_r <= ss_nxt;

  // the pin is driven high while entering, then released so the wake pulse can pull it low
  assign suspend_wake_pin_out    = (ss_r == periph_dma_pkg::SS_ENTER);
  assign suspend_wake_pin_oe_out = (ss_r != periph_dma_pkg::SS_SUSP);
  assign internal_clk_run_out    = (ss_r != periph_dma_pkg::SS_SUSP) || clock_run_bit_in;
  assign drive_k_state_out       = (ss_r == periph_dma_pkg::SS_KDRIVE);
  assign irq_out = (suspend_flag_out && suspend_irq_enable_in) ||
                   (resume_flag_out && resume_irq_enable_in);

  // flags: a new event wins over a clear in the same cycle; clears refused while locked
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      susp_cond_q_r     <= 1'h0;
      suspend_flag_out  <= 1'h0;
      resume_flag_out   <= 1'h0;
      register_lock_out <= 1'h0;
    end
    else if (clk_en_in)
    begin
      susp_cond_q_r <= susp_cond;
      if (susp_cond && !susp_cond_q_r)
        suspend_flag_out <= 1'h1;
      else if (irq_flag_clear_in[0] && !register_lock_out)
        suspend_flag_out <= 1'h0;
      if (ss_r == periph_dma_pkg::SS_SUSP && st_done && wake_any)
        resume_flag_out <= 1'h1;
      else if (irq_flag_clear_in[1] && !register_lock_out)
        resume_flag_out <= 1'h0;
      if (ss_r == periph_dma_pkg::SS_SUSP && st_done && wake_any)
        register_lock_out <= 1'h1;
      else if (unlock_device_in)
        register_lock_out <= 1'h0;
    end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_DRIVE_ON_READ: assert property (fly_by && dma_acknowledge_in && dma_read_strobe_in &&
    !dir_in |-> data_oe_out) else $error("data not driven during read strobe");
  AST_RELEASE_BUS: assert property (!dma_acknowledge_in |-> !data_oe_out)
    else $error("data bus driven without acknowledge");
  AST_SINGLE_DROP: assert property (clk_en_in && word_done && !burst_mode_in &&
    dma_acknowledge_in |=> !dma_request_out) else $error("request kept after single word");
  AST_COUNT_EOT: assert property (clk_en_in && xs_r == periph_dma_pkg::XS_RUN &&
    dma_enable_bit_in && count_termination_enable_in && cnt_hit
    |=> xs_r == periph_dma_pkg::XS_DONE && eot_event_out) else $error("count end missed");
  AST_CLEAR_SILENT: assert property (clk_en_in && xs_r == periph_dma_pkg::XS_RUN &&
    !dma_enable_bit_in |=> xs_r == periph_dma_pkg::XS_IDLE && !eot_event_out)
    else $error("enable clear not silent");
  AST_DONE_NO_REQ: assert property (xs_r == periph_dma_pkg::XS_DONE |-> !dma_request_out)
    else $error("request after termination");
  AST_EXT_EOT: assert property (clk_en_in && xs_r == periph_dma_pkg::XS_RUN &&
    dma_enable_bit_in && transfer_termination_in && dma_acknowledge_in
    |=> xs_r == periph_dma_pkg::XS_DONE && !dma_request_out) else $error("external end missed");
  AST_EP_SELECT: assert property (dma_endpoint_select_in < `PD_EPSEL_FIRST |->
    !dma_request_out) else $error("request for reserved endpoint code");
  AST_SUSP_FLAG: assert property (clk_en_in && susp_cond && !susp_cond_q_r
    |=> suspend_flag_out) else $error("suspend flag not set");
  AST_PIN_HIGH: assert property (clk_en_in && ss_r == periph_dma_pkg::SS_ARMED &&
    !go_suspend_bit_in |=> suspend_wake_pin_out && suspend_wake_pin_oe_out)
    else $error("pin not high on suspend entry");
  AST_MIN_SUSP: assert property (clk_en_in && ss_r == periph_dma_pkg::SS_SUSP && !st_done
    |=> ss_r == periph_dma_pkg::SS_SUSP) else $error("woke before minimum suspend");
  AST_WAKE_LOCK: assert property (clk_en_in && ss_r == periph_dma_pkg::SS_SUSP &&
    ss_nxt != periph_dma_pkg::SS_SUSP |=> resume_flag_out && register_lock_out &&
    !suspend_wake_pin_out) else $error("wake without flag and lock");
  COV_COUNT_END: cover property (xs_r == periph_dma_pkg::XS_RUN ##1 xs_r == periph_dma_pkg::XS_DONE);
  COV_REMOTE_WAKE: cover property (ss_r == periph_dma_pkg::SS_KDRIVE);
  COV_BURST_HOLD: cover property (burst_mode_in && hold_r && dma_acknowledge_in);
endmodule

// ==== tb/dma_partner.sv ====
// fly-by dma controller model answering the device request one word at a time
`timescale 1ns/10ps
module dma_partner (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic req_in,
  output logic      ack_out,
  output logic      rd_out
);
  logic [1:0] ph_r;
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      ph_r <= 2'h0;
    else if (ph_r != 2'h0 || req_in)
      ph_r <= ph_r + 2'h1;
  assign ack_out = ph_r != 2'h0;
  assign rd_out  = ph_r == 2'h1 || ph_r == 2'h2;
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the dma end-of-transfer and suspend controller
`timescale 1ns/10ps
module tb_top;
  logic core_clk_in = 0, rst_n_in = 0, clk_en_in = 1, vbus_present_in = 1, seen;
  logic chip_select_n_in = 1, suspend_wake_pin_in = 1, clock_run_bit_in = 1, ep_wr_ready_in = 1;
  logic ep_rd_valid_in = 1, dma_enable_bit_in = 0, count_termination_enable_in = 0;
  logic bus_idle_in = 0, go_suspend_bit_in = 0, short_packet_termination_enable_in = 0;
  logic endpoint_direction_bit_in = 0, iso_endpoint_in = 0, ack_only_mode_bit_in = 0;
  logic burst_mode_in = 0, dma_write_strobe_in = 0, unlock_device_in = 0, sof_in = 0;
  logic transfer_termination_in = 0, ep_packet_ready_in = 0, ep_rd_short_last_in = 0;
  logic ep_in_partial_in = 0, ep_eop_in = 0, bus_k_state_in = 0, chip_select_wake_enable_in = 0;
  logic suspend_irq_enable_in = 0, resume_irq_enable_in = 0, dma_acknowledge_in;
  logic dma_read_strobe_in, data_oe_out, dma_request_out, eot_event_out, ep_rd_ready_out;
  logic ep_wr_valid_out, irq_out, suspend_wake_pin_out, suspend_wake_pin_oe_out;
  logic suspend_flag_out, resume_flag_out, bus_state_bit_out, internal_clk_run_out;
  logic drive_k_state_out, register_lock_out;
  logic [3:0]  dma_endpoint_select_in = 4'h3, dma_endpoint_out;
  logic [2:0]  burst_len_in = 3'h0;
  logic [1:0]  irq_flag_clear_in = 2'h0;
  logic [15:0] dma_byte_count_reg_in = 16'h0004, data_in = 16'h0000, ep_rd_data_in = 16'h5A3C;
  logic [15:0] data_out, dma_count_left_out, ep_wr_data_out;
  int          fail_count = 0, cmp_count = 0, k_cycles;
  periph_dma_eot_suspend_ctrl #(.IDLE_CYC(20), .CLKOFF_CYC(10), .MINSUSP_CYC(30), .KDRIVE_CYC(40))
    periph_dma_eot_suspend_ctrl_i (.*);
  dma_partner dma_partner_i (.clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_in(dma_request_out),
    .ack_out(dma_acknowledge_in), .rd_out(dma_read_strobe_in));
  initial
    forever #25 core_clk_in = ~core_clk_in;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // sampling on the falling edge keeps clear of the launch edge updates
  task automatic wt(ref logic s);
    int i;
    for (i = 0; i < 300 && s !== 1'b1; i++)
      @(negedge core_clk_in);
    if (i == 300)
    begin
      fail_count++;
      end_sim;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(negedge core_clk_in);
    chk("request", 0, dma_request_out);
    chk("lock", 0, register_lock_out);
    $display("test reset done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b1;
    count_termination_enable_in <= 1'b1;
    wt(data_oe_out);
    chk("data", 16'h5A3C, data_out);
    chk("endpoint", 4'h2, dma_endpoint_out);
    wt(eot_event_out);
    chk("count", 0, dma_count_left_out);
    repeat (10) @(negedge core_clk_in);
    chk("request", 0, dma_request_out);
    $display("test count done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b0;
    count_termination_enable_in <= 1'b0;
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b1;
    wt(data_oe_out);
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b0;
    seen = 1'b0;
    repeat (8) @(negedge core_clk_in) seen |= eot_event_out;
    chk("halt eot", 0, seen);
    $display("test halt done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b1;
    transfer_termination_in <= 1'b1;
    wt(eot_event_out);
    repeat (6) @(negedge core_clk_in);
    chk("ext request", 0, dma_request_out);
    $display("test ext done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b0;
    transfer_termination_in <= 1'b0;
    short_packet_termination_enable_in <= 1'b1;
    ep_rd_short_last_in <= 1'b1;
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b1;
    wt(eot_event_out);
    chk("short count", 16'h0002, dma_count_left_out);
    $display("test short done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b0;
    short_packet_termination_enable_in <= 1'b0;
    ep_rd_short_last_in <= 1'b0;
    iso_endpoint_in <= 1'b1;
    ep_eop_in <= 1'b1;
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b1;
    wt(eot_event_out);
    $display("test iso done");
    @(posedge core_clk_in);
    dma_enable_bit_in <= 1'b0;
    iso_endpoint_in <= 1'b0;
    ep_eop_in <= 1'b0;
    bus_idle_in <= 1'b1;
    wt(suspend_flag_out);
    chk("irq", 0, irq_out);
    @(posedge core_clk_in);
    suspend_irq_enable_in <= 1'b1;
    @(negedge core_clk_in);
    chk("irq on", 1, irq_out);
    chk("bus state", 1, bus_state_bit_out);
    @(posedge core_clk_in);
    suspend_irq_enable_in <= 1'b0;
    resume_irq_enable_in <= 1'b1;
    clock_run_bit_in <= 1'b0;
    go_suspend_bit_in <= 1'b1;
    @(posedge core_clk_in);
    go_suspend_bit_in <= 1'b0;
    repeat (3) @(negedge core_clk_in);
    chk("pin", 2'h3, {suspend_wake_pin_oe_out, suspend_wake_pin_out});
    chk("clock", 1, internal_clk_run_out);
    repeat (20) @(negedge core_clk_in);
    chk("clock off", 0, internal_clk_run_out);
    chk("irq off", 0, irq_out);
    @(posedge core_clk_in);
    suspend_wake_pin_in <= 1'b0;
    repeat (10) @(negedge core_clk_in);
    chk("early wake", 0, {drive_k_state_out, resume_flag_out});
    wt(drive_k_state_out);
    chk("resume", 1, resume_flag_out);
    chk("irq resume", 1, irq_out);
    chk("remote lock", 1, register_lock_out);
    chk("remote pin", 0, suspend_wake_pin_out);
    for (k_cycles = 0; k_cycles < 100 && drive_k_state_out === 1'b1; k_cycles++)
      @(negedge core_clk_in);
    chk("k cycles", 40, k_cycles);
    $display("test wake done");
    @(posedge core_clk_in);
    suspend_wake_pin_in <= 1'b1;
    unlock_device_in <= 1'b1;
    @(posedge core_clk_in);
    unlock_device_in <= 1'b0;
    irq_flag_clear_in <= 2'h2;
    @(posedge core_clk_in);
    irq_flag_clear_in <= 2'h0;
    go_suspend_bit_in <= 1'b1;
    @(negedge core_clk_in);
    chk("unlocked", 0, {register_lock_out, resume_flag_out});
    @(posedge core_clk_in);
    go_suspend_bit_in <= 1'b0;
    repeat (60) @(posedge core_clk_in);
    bus_k_state_in <= 1'b1;
    wt(resume_flag_out);
    chk("lock", 1, register_lock_out);
    chk("pin low", 0, suspend_wake_pin_out);
    chk("host k", 0, drive_k_state_out);
    $display("test suspend done");
    end_sim;
  end
endmodule
